// ===== aasp_top.sv
// serial audio output port with axi4-lite control register
// assumes link pins arrive asynchronous and are resolved outside from the enables
//
// Overview of operation
// - four formats, msb first, word lengths 16 to 32 bits
// - right justified with 32-bit setting falls back to 24-bit words
// - data bits change on the falling bit clock edge
// - left and right words share one data line, align clock selects channel
// - left justified: msb at first rising edge after align transition
// - i2s style: msb at second rising edge after align transition
// - right justified: lsb lands just before the next align transition
// - dsp: msb on first or second edge after sync rise, right follows left
// - align clock changes only on falling bit clock edges
// - master: align clock 50:50, bit clock at 64 times sample rate
// - format field bits 1:0, reset 10, selects the four formats
// - word length field bits 3:2, reset 10, selects 16/20/24/32
// - samples from 24-bit data, truncated for 16/20, zero padded for 32
// - bit 6 selects master (1) or slave (0)
// - bit 7 inverts the bit clock interpretation
// - data pin always output, low at reset and on leaving standby
// - master bit clock output defaults low
// - master timing derived from the local reference clock
//
// Design decision made here: the AXI4-Lite interface to the registers.
module aasp_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [23:0] left_sample,
  input  wire logic [23:0] right_sample,
  input  wire logic        standby,
  input  wire logic        bitclk_in,
  output logic             bitclk_out,
  output logic             bitclk_oe,
  input  wire logic        channel_align_clock_in,
  output logic             channel_align_clock_out,
  output logic             channel_align_clock_oe,
  output logic             serial_sample_out
);

  logic [8:0]  fmt_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // bus slave: address and data taken in either order, one write at a time
  wire aw_take   = s_axi_awvalid && awready_r;
  wire w_take    = s_axi_wvalid && wready_r;
  wire aw_have   = aw_held_r || aw_take;
  wire w_have    = w_held_r || w_take;
  wire [7:0]  wa = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wd = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0]  ws = w_held_r ? wstrb_r : s_axi_wstrb;
  wire do_write  = aw_have && w_have && !bvalid_r;
  wire wr_fmt    = do_write && (wa == aasp_pkg::FMT_ADDR);
  wire wr_stat   = do_write && (wa == aasp_pkg::STAT_ADDR);
  wire b_done    = bvalid_r && s_axi_bready;
  wire ar_take   = s_axi_arvalid && arready_r;
  wire r_done    = rvalid_r && s_axi_rready;

  // byte lane 1 reaches only bit 8, which stays zero like bit 5
  wire [8:0] strb_mask = {ws[1], {8{ws[0]}}} & aasp_pkg::FMT_WMASK;
  wire [8:0] fmt_nxt   = (fmt_r & ~strb_mask) | (wd[8:0] & strb_mask);

  // a write takes effect at once; software must hold the link idle while it changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fmt_r <= aasp_pkg::FMT_RESET;
    end else if (wr_fmt) begin
      fmt_r <= fmt_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awready_r <= 1'b1;
      awaddr_r  <= 8'h00;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
      awready_r <= 1'b0;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      awready_r <= 1'b0;
      awaddr_r  <= s_axi_awaddr;
    end else if (b_done) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wready_r <= 1'b1;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (do_write) begin
      w_held_r <= 1'b0;
      wready_r <= 1'b0;
    end else if (w_take) begin
      w_held_r <= 1'b1;
      wready_r <= 1'b0;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (b_done) begin
      wready_r <= 1'b1;
    end
  end

  // status register is read only; a write to it is answered okay and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= aasp_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wr_fmt || wr_stat) ? aasp_pkg::RESP_OKAY : aasp_pkg::RESP_SLVERR;
    end else if (b_done) begin
      bvalid_r <= 1'b0;
    end
  end

  // link pin synchronisers: bit 1 align clock, bit 0 bit clock
  // filt_r moves only when the second and third stages agree, so a one-cycle glitch makes no edge
  logic [1:0] sy1_r;
  logic [1:0] sy2_r;
  logic [1:0] sy3_r;
  logic [1:0] filt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_r  <= 2'h0;
      sy2_r  <= 2'h0;
      sy3_r  <= 2'h0;
      filt_r <= 2'h0;
    end else begin
      sy1_r  <= {channel_align_clock_in, bitclk_in};
      sy2_r  <= sy1_r;
      sy3_r  <= sy2_r;
      filt_r <= (sy2_r & sy3_r) | (filt_r & (sy2_r | sy3_r));
    end
  end

  wire [1:0] fmt_f   = fmt_r[aasp_pkg::F_FORMAT +: 2];
  wire [1:0] wl_f    = fmt_r[aasp_pkg::F_WLEN +: 2];
  wire       phase_f = fmt_r[aasp_pkg::F_PHASE];
  wire       master  = fmt_r[aasp_pkg::F_ROLE];
  wire       inv     = fmt_r[aasp_pkg::F_INV];
  wire       is_dsp  = (fmt_f == aasp_pkg::AASP_DSP);
  wire       is_rj   = (fmt_f == aasp_pkg::AASP_RJ);

  wire [1:0] wl_eff  = (is_rj && wl_f == aasp_pkg::WL_32) ? aasp_pkg::WL_24 : wl_f;
  wire [6:0] n_len   = aasp_pkg::wl_len(wl_eff);

  // master clock generator, runs off the local reference only
  // the half period rounds down, so the master sample rate runs slightly above nominal
  logic [4:0] div_r;
  logic       gen_r;
  logic [5:0] pos_r;
  logic       lrc_m_r;

  wire half_tick = (div_r == aasp_pkg::HALF_LAST);
  wire run_gen   = master && !standby;

  always_ff @(posedge aclk) begin
    if (!aresetn || !run_gen) begin
      div_r <= 5'h00;
      gen_r <= 1'b0;
    end else if (half_tick) begin
      div_r <= 5'h00;
      gen_r <= !gen_r;
    end else begin
      div_r <= div_r + 5'h01;
    end
  end

  // effective bit clock after role mux and inversion
  // a slave launch lags the pin edge by four or five aclk through the synchroniser,
  // so at high bit clock rates the controller must sample late in the bit period
  wire bc_eff = (master ? gen_r : filt_r[0]) ^ inv;
  logic bc_prev_r;
  wire  launch = bc_prev_r && !bc_eff;

  // pos_r starts one short of zero so the first launch opens a low align phase
  wire [5:0] pos_nxt   = pos_r + 6'h01;
  wire       lrc_m_nxt = pos_nxt[5]; // 32 periods high, 32 low
  wire       lrc_now   = master ? lrc_m_nxt : filt_r[1];

  always_ff @(posedge aclk) begin
    if (!aresetn || !run_gen) begin
      pos_r   <= 6'h3f;
      lrc_m_r <= 1'b0;
    end else if (launch) begin
      pos_r   <= pos_nxt;
      lrc_m_r <= lrc_m_nxt;
    end
  end

  // slot tracking
  logic       lrc_prev_r;
  logic [6:0] cnt_r;
  logic [6:0] last_len_r;
  logic [23:0] hold_l_r;
  logic [23:0] hold_r_r;
  logic        data_r;

  wire lrc_edge  = (lrc_now != lrc_prev_r);
  wire lrc_rise  = lrc_edge && lrc_now;
  wire slot_new  = is_dsp ? lrc_rise : lrc_edge;
  wire [6:0] cnt_inc = (cnt_r == 7'h7f) ? cnt_r : cnt_r + 7'h01;
  wire [6:0] k       = slot_new ? 7'h00 : cnt_inc;

  // i2s puts left on the low phase, justified formats on the high phase
  wire left_lvl = (fmt_f != aasp_pkg::AASP_I2S);
  wire is_left  = (lrc_now == left_lvl);
  // both samples are latched together so a left/right pair never straddles a filter update
  wire capture  = slot_new && (is_dsp || is_left);
  wire [23:0] smp_l = capture ? left_sample : hold_l_r;
  wire [23:0] smp_r = capture ? right_sample : hold_r_r;

  // start offset of the word inside the slot
  // right justified needs the slot length before the slot ends; it trusts the previous one,
  // so a slave slot that changes length shifts the word for one slot
  wire [6:0] rj_st = (last_len_r > n_len) ? last_len_r - n_len : 7'h00;
  wire [6:0] st    = (fmt_f == aasp_pkg::AASP_LJ)  ? 7'h00 :
                     (fmt_f == aasp_pkg::AASP_I2S) ? 7'h01 :
                     is_dsp ? {6'h00, phase_f} : rj_st;
  wire       in_word = (k >= st);
  wire [6:0] j       = k - st;

  // dsp packs the right word straight after the left one
  wire       dsp_rt  = (j >= n_len);
  wire [6:0] j_dsp   = dsp_rt ? j - n_len : j;
  wire       bit_dsp = dsp_rt ? aasp_pkg::word_bit(smp_r, j_dsp, n_len) : aasp_pkg::word_bit(smp_l, j_dsp, n_len);
  wire       bit_std = is_left ? aasp_pkg::word_bit(smp_l, j, n_len) : aasp_pkg::word_bit(smp_r, j, n_len);
  // word_bit gives zero past the word: truncation and padding both follow from it
  wire       bit_nxt = in_word && (is_dsp ? bit_dsp : bit_std);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bc_prev_r <= 1'b0;
    end else begin
      bc_prev_r <= bc_eff;
    end
  end

  // a slave rj slot shorter than the word simply starts at bit 0 and cuts the tail
  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      lrc_prev_r <= 1'b0;
      cnt_r      <= 7'h7f;
      last_len_r <= 7'h20;
      data_r     <= 1'b0;
    end else if (launch) begin
      lrc_prev_r <= lrc_now;
      cnt_r      <= k;
      data_r     <= bit_nxt;
      if (lrc_edge && !is_dsp) begin
        last_len_r <= cnt_inc;
      end
    end
  end

  // the right word is sent after the left slot has moved on, so both are held here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_l_r <= 24'h000000;
      hold_r_r <= 24'h000000;
    end else if (launch && capture) begin
      hold_l_r <= left_sample;
      hold_r_r <= right_sample;
    end
  end

  // read side
  // reads have no side effects; a slow rready only delays the next read
  wire [31:0] stat_word = {17'h00000, last_len_r, 4'h0, wl_eff, master, lrc_prev_r};
  wire        rd_fmt    = (s_axi_araddr == aasp_pkg::FMT_ADDR);
  wire        rd_stat   = (s_axi_araddr == aasp_pkg::STAT_ADDR);
  wire [31:0] rd_word   = rd_fmt  ? {23'h000000, fmt_r} :
                          rd_stat ? stat_word : 32'h0000_0000;
  wire        rd_hit    = rd_fmt || rd_stat;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= aasp_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_word;
      rresp_r   <= rd_hit ? aasp_pkg::RESP_OKAY : aasp_pkg::RESP_SLVERR;
    end else if (r_done) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  assign s_axi_awready           = awready_r;
  assign s_axi_wready            = wready_r;
  assign s_axi_bvalid            = bvalid_r;
  assign s_axi_bresp             = bresp_r;
  assign s_axi_arready           = arready_r;
  assign s_axi_rvalid            = rvalid_r;
  assign s_axi_rdata             = rdata_r;
  assign s_axi_rresp             = rresp_r;
  assign bitclk_out              = gen_r;
  assign bitclk_oe               = fmt_r[aasp_pkg::F_ROLE];
  assign channel_align_clock_out = lrc_m_r;
  assign channel_align_clock_oe  = fmt_r[aasp_pkg::F_ROLE];
  assign serial_sample_out       = data_r;

endmodule

// ===== aasp_pkg.sv
// constants, types and helper functions for the audio serial output port
// assumes a single 100 MHz bus clock shared with the filter data source
package aasp_pkg;

  // register indices; byte address is four times the index
  localparam int         FMT_REG_IDX  = 7;
  localparam int         STAT_REG_IDX = 8;
  localparam logic [7:0] FMT_ADDR     = 8'(FMT_REG_IDX * 4);
  localparam logic [7:0] STAT_ADDR    = 8'(STAT_REG_IDX * 4);

  // control register layout
  localparam int         FMT_W       = 9;
  localparam int         F_FORMAT    = 0;
  localparam int         F_WLEN      = 2;
  localparam int         F_PHASE     = 4;
  localparam int         F_ROLE      = 6;
  localparam int         F_INV       = 7;
  localparam logic [8:0] FMT_RESET   = 9'h00a;
  localparam logic [8:0] FMT_WMASK   = 9'h0df;

  // status register layout
  localparam int         S_ALIGN     = 0;
  localparam int         S_ROLE      = 1;
  localparam int         S_WLEN      = 2;
  localparam int         S_SLOTLEN   = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    AASP_RJ  = 2'h0,
    AASP_LJ  = 2'h1,
    AASP_I2S = 2'h2,
    AASP_DSP = 2'h3
  } aasp_fmt_e;

  localparam logic [1:0] WL_24 = 2'h2;
  localparam logic [1:0] WL_32 = 2'h3;

  // master timing
  localparam longint CLK_HZ      = 100_000_000;
  localparam longint FS_HZ       = 48_000;
  localparam longint BCLK_PER_FS = 64;
  localparam int     BCLK_HALF   = int'(CLK_HZ / (2 * BCLK_PER_FS * FS_HZ));
  localparam logic [4:0] HALF_LAST = 5'(BCLK_HALF - 1);

  function automatic logic [6:0] wl_len(input logic [1:0] code);
    case (code)
      2'h0:    wl_len = 7'h10;
      2'h1:    wl_len = 7'h14;
      2'h2:    wl_len = 7'h18;
      default: wl_len = 7'h20;
    endcase
  endfunction

  // bit j (0 = msb) of a word of n bits built from a 24-bit sample
  function automatic logic word_bit(input logic [23:0] s, input logic [6:0] j, input logic [6:0] n);
    logic [31:0] w;
    w = {s, 8'h00};
    word_bit = (j < n) ? w[5'h1f - j[4:0]] : 1'b0;
  endfunction

endpackage

// ===== aasp_assertions.sv
// pin and bus checks for the audio serial port
// assumes the ports of aasp_top and a single aclk domain
module aasp_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic standby,
  input wire logic bitclk_out,
  input wire logic bitclk_oe,
  input wire logic channel_align_clock_out,
  input wire logic channel_align_clock_oe,
  input wire logic serial_sample_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [10:0] gap_r;
  logic        seen_r;
  // the first align edge after going master is not timed
  always_ff @(posedge aclk) begin
    if (!aresetn || !bitclk_oe) begin
      gap_r  <= 11'h000;
      seen_r <= 1'b0;
    end else if ($changed(channel_align_clock_out)) begin
      gap_r  <= 11'h000;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 11'h001;
    end
  end
  a_standby_low: assert property (standby |=> !serial_sample_out)
    else $error("serial data not low in standby");
  a_oe_pair: assert property (bitclk_oe == channel_align_clock_oe)
    else $error("clock enables differ");
  a_bclk_idle: assert property (!bitclk_oe |-> !bitclk_out)
    else $error("bit clock output not low as slave");
  a_bclk_half: assert property (bitclk_oe && $rose(bitclk_out) |-> ##16 $fell(bitclk_out))
    else $error("bit clock half period wrong");
  a_data_launch: assert property (
    bitclk_oe && $changed(serial_sample_out) |-> $past(bitclk_out, 2) && !$past(bitclk_out))
    else $error("data changed away from a falling bit clock");
  a_align_launch: assert property (
    bitclk_oe && $changed(channel_align_clock_out) |-> $past(bitclk_out, 2) && !$past(bitclk_out))
    else $error("align changed away from a falling bit clock");
  a_align_half: assert property (
    bitclk_oe && seen_r && $changed(channel_align_clock_out) |-> gap_r == 11'h3ff)
    else $error("align phase not 32 bit periods");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
endmodule
bind aasp_top aasp_assertions aasp_assertions_inst (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .standby, .bitclk_out,
  .bitclk_oe, .channel_align_clock_out, .channel_align_clock_oe, .serial_sample_out
);

// ===== aasp_link_model.sv
// far-side audio controller: makes slave clocks and collects serial words
// assumes the bench resolves both clock pins from the enables
module aasp_link_model (
  input  wire logic   bck_w,
  input  wire logic   lrc_w,
  input  wire logic   sdo,
  input  wire logic   run,
  output logic        bck_drv,
  output logic        lrc_drv,
  output logic [31:0] word_lo,
  output logic [31:0] word_hi
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] sh = 32'h0;
  logic        lrc_q = 1'b0;
  int          n = 0;
  initial begin
    bck_drv = 1'b0;
    lrc_drv = 1'b0;
  end
  // bit clock stands low outside frames; align clock keeps its last level
  always begin
    if (!run) begin
      @(posedge run);
      #3;
    end
    #40 bck_drv = 1'b1;
    #40 bck_drv = 1'b0;
    n = n + 1;
    // 32 bit periods per phase covers any word
    if (n == 32) begin
      n = 0;
      lrc_drv <= ~lrc_drv;
    end
  end
  // sampled at the next fall: the port answers too late for the rising edge at this rate
  always @(negedge bck_w) begin
    if (lrc_w !== lrc_q) begin
      if (lrc_q) word_hi <= sh;
      else word_lo <= sh;
      sh = {31'h0, sdo};
    end else begin
      sh = {sh[30:0], sdo};
    end
    lrc_q = lrc_w;
  end
endmodule

// ===== aasp_top_tb.sv
// self-checking bench: register bus, standby, slave and master frames
// assumes aasp_link_model as far side and a 100 MHz aclk
module aasp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] lv = 24'h9a5c3e;
  localparam logic [23:0] rv = 24'h5b71c4;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        standby = 1'b0;
  logic        run = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d, w_lo, w_hi;
  logic        bitclk_out, bitclk_oe, channel_align_clock_out, channel_align_clock_oe;
  logic        serial_sample_out, bck_drv, lrc_drv;
  wire logic   bck_w = bitclk_oe ? bitclk_out : bck_drv;
  wire logic   lrc_w = channel_align_clock_oe ? channel_align_clock_out : lrc_drv;
  int          mismatches = 0;
  int          checked = 0;
  int          cyc = 0;

  always #5 aclk = ~aclk;

  aasp_top aasp_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .left_sample(lv), .right_sample(rv), .standby, .bitclk_in(bck_w), .bitclk_out, .bitclk_oe,
    .channel_align_clock_in(lrc_w), .channel_align_clock_out, .channel_align_clock_oe, .serial_sample_out
  );
  aasp_link_model aasp_link_model_inst (
    .bck_w, .lrc_w, .sdo(serial_sample_out), .run, .bck_drv, .lrc_drv, .word_lo(w_lo), .word_hi(w_hi)
  );

  task automatic finish_test();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, {30'h0, aasp_pkg::RESP_OKAY});
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic t_reset();
    axi_rd(aasp_pkg::FMT_ADDR);
    check(d, {23'h0, aasp_pkg::FMT_RESET});
    check({29'h0, bitclk_oe, bitclk_out, serial_sample_out}, 32'h0);
    axi_wr(aasp_pkg::FMT_ADDR, 32'h1bf);
    axi_rd(aasp_pkg::FMT_ADDR);
    check(d, 32'h09f);
    axi_rd(8'h40);
    check({30'h0, r}, {30'h0, aasp_pkg::RESP_SLVERR});
    check(d, 32'h0);
  endtask

  task automatic t_standby();
    axi_wr(aasp_pkg::FMT_ADDR, 32'h009);
    run <= 1'b1;
    repeat (300) @(posedge aclk);
    standby <= 1'b1;
    repeat (100) @(posedge aclk);
    check({31'h0, serial_sample_out}, 32'h0);
    standby <= 1'b0;
    run <= 1'b0;
    @(posedge aclk);
    check({31'h0, serial_sample_out}, 32'h0);
  endtask

  // lo and hi are the words seen while align is low and high
  task automatic frame(input logic [8:0] c, input logic [31:0] lo, input logic [31:0] hi);
    logic [1:0] wl;
    wl = (c[1:0] == aasp_pkg::AASP_RJ && c[3:2] == aasp_pkg::WL_32) ? aasp_pkg::WL_24 : c[3:2];
    axi_wr(aasp_pkg::FMT_ADDR, {23'h0, c});
    axi_rd(aasp_pkg::FMT_ADDR);
    check(d, {23'h0, c});
    run <= !c[aasp_pkg::F_ROLE];
    repeat (c[aasp_pkg::F_ROLE] ? 7000 : 2000) @(posedge aclk);
    run <= 1'b0;
    repeat (50) @(posedge aclk);
    check(w_lo, lo);
    check(w_hi, hi);
    // every slot of the model is 32 bit periods; bit 0 follows the link and is left out
    axi_rd(aasp_pkg::STAT_ADDR);
    check(d & 32'h0000_7ffe, {17'h0, 7'h20, 4'h0, wl, c[aasp_pkg::F_ROLE], 1'h0});
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_reset();
    t_standby();
    frame(9'h009, {rv, 8'h00}, {lv, 8'h00});
    // inverted: launch follows the rising pin edge, so the falling-edge capture sees each slot one bit late
    frame(9'h089, {1'h0, rv, 7'h00}, {1'h0, lv, 7'h00});
    frame(9'h002, {1'b0, lv[23:8], 15'h0}, {1'b0, rv[23:8], 15'h0});
    frame(9'h006, {1'b0, lv[23:4], 11'h0}, {1'b0, rv[23:4], 11'h0});
    frame(9'h00e, {1'b0, lv, 7'h00}, {1'b0, rv, 7'h00});
    frame(9'h00c, {8'h00, rv}, {8'h00, lv});
    frame(9'h000, {16'h0, rv[23:8]}, {16'h0, lv[23:8]});
    frame(9'h003, 32'h0, {lv[23:8], rv[23:8]});
    frame(9'h017, {rv[12:4], 23'h0}, {1'b0, lv[23:4], rv[23:13]});
    frame(9'h049, {rv, 8'h00}, {lv, 8'h00});
    finish_test();
  end
endmodule
